// File: hdl/cpu_state_pkg.sv
package cpu_state_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 12;  // Program counter width
  localparam int DATA_W = 8;  // Data byte width
  localparam int STACK_DEPTH = 4;  // Return stack levels

  // ----------------------------------------------------------------
  // Program space map
  // ----------------------------------------------------------------
  localparam logic [11:0] SELFTEST_ROM_BASE = 12'hae0;  // Self-test ROM start
  localparam logic [11:0] PROG_ROM_BASE = 12'hc00;  // Program ROM start
  localparam logic [11:0] PROG_ROM_LAST = 12'hff7;  // Program ROM end
  localparam logic [11:0] VEC_ST_IRQ = 12'hff8;  // Self-test interrupt vector
  localparam logic [11:0] VEC_ST_RESTART = 12'hffa;  // Self-test restart vector
  localparam logic [11:0] VEC_USER_IRQ = 12'hffc;  // User interrupt vector
  localparam logic [11:0] VEC_USER_RESTART = 12'hffe;  // User restart vector
  localparam logic [7:0] RESERVED_FILL = 8'hff;  // Reserved region reads ones

  // ----------------------------------------------------------------
  // Data space map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_A_VALUE = 8'h00;  // Port A data
  localparam logic [7:0] ADDR_PORT_B_VALUE = 8'h01;  // Port B data
  localparam logic [7:0] ADDR_PORT_C_VALUE = 8'h02;  // Port C data
  localparam logic [7:0] ADDR_PORT_A_DIR = 8'h04;  // Port A direction
  localparam logic [7:0] ADDR_PORT_B_DIR = 8'h05;  // Port B direction
  localparam logic [7:0] ADDR_PORT_C_DIR = 8'h06;  // Port C direction
  localparam logic [7:0] ADDR_TIMER_STATUS = 8'h08;  // Timer status and control
  localparam logic [7:0] ADDR_DROM_BASE = 8'h20;  // Data ROM start
  localparam logic [7:0] ADDR_DROM_LAST = 8'h5f;  // Data ROM end
  localparam logic [7:0] ADDR_POINTER_FIRST = 8'h80;  // First pointer
  localparam logic [7:0] ADDR_POINTER_SECOND = 8'h81;  // Second pointer
  localparam logic [7:0] ADDR_RAM_BASE = 8'h80;  // Data RAM start
  localparam logic [7:0] ADDR_RAM_LAST = 8'h9f;  // Data RAM end
  localparam logic [7:0] ADDR_PRESCALER = 8'hfd;  // Prescaler value
  localparam logic [7:0] ADDR_TIMER_COUNT = 8'hfe;  // Timer count value
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'hff;  // Work accumulator
  localparam logic [7:0] UNMAPPED_FILL = 8'hff;  // Unmapped read value
  localparam logic [7:0] PORT_C_FIXED = 8'hf0;  // Port C upper bits as ones

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_RESET = 8'h00;  // Port registers after reset
  localparam logic [7:0] TIMER_STATUS_RESET = 8'h00;  // Timer status after reset
  localparam logic [7:0] COUNT_RESET = 8'hff;  // Count and prescaler after reset
  localparam logic [7:0] ACC_RESET = 8'h00;  // Accumulator after reset
  localparam logic [11:0] PC_RESET = 12'h000;  // Counter before restart load

  // ----------------------------------------------------------------
  // Flag update selectors
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CARRY_KEEP,
    CARRY_ALU,
    CARRY_BIT,
    CARRY_ROTATE
  } carry_op_t;

endpackage

// File: hdl/return_stack.sv
`timescale 1ns/1ps
`default_nettype none

// Four level shift stack, no pointer; bottom level sticks on pop
module return_stack #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Control
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] push_data_i,
  // Top level, registered
  output logic [WIDTH-1:0] top_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] level_reg [DEPTH];  // Level 0 is the top
  logic [WIDTH-1:0] level_next [DEPTH];  // Next values

  // Shift down on push, up on pop; push wins if both
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      level_next[i] = level_reg[i];
    end
    if (push_i)
    begin
      level_next[0] = push_data_i;
      for (int i = 1; i < DEPTH; i++)
      begin
        level_next[i] = level_reg[i-1];
      end
    end
    else if (pop_i)
    begin
      // Bottom keeps its value so repeated pops keep returning it
      for (int i = 0; i < DEPTH-1; i++)
      begin
        level_next[i] = level_reg[i+1];
      end
    end
  end

  // Register the levels
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        level_reg[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        level_reg[i] <= level_next[i];
      end
    end
  end

  assign top_o = level_reg[0];

endmodule

`default_nettype wire

// File: hdl/data_ram.sv
`timescale 1ns/1ps
`default_nettype none

// Small data RAM with registered read data
module data_ram #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  logic [DW-1:0] mem [2**AW];  // Not reset, as real RAM

  // Write and registered read; read sees old data on collision
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

`default_nettype wire

// File: hdl/cpu_state_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - 12-bit program space, address output only
// - Decode ports, directions, timer status
// - Accumulator lives at data address FF
// - Pointers are RAM bytes 80 and 81
// - Twelve bit program counter, low and high
// - Carry follows ALU carry or borrow
// - Bit test and rotate use carry
// - Zero set on zero result
// - Interrupt selects second flag copy, return restores
// - Only current mode flags are touched
// - Interrupt copy keeps values across entries
// - Reset clears both flag copies
// - Four level 12-bit stack, no pointer
// - Push shifts all levels deeper
// - Pop loads top, shifts up
// - Extra pops repeat the bottom value
// - Core reaches memory only through buses
// - 256 byte data, 4096 byte program
// - Interrupt sets mask, return clears it
module cpu_state_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Data bus from the core
  input wire logic [7:0] data_addr_i,
  input wire logic data_rd_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  output logic [7:0] data_rdata_o,
  // Program counter control
  input wire logic pc_load_i,
  input wire logic [11:0] pc_load_value_i,
  input wire logic pc_inc_i,
  input wire logic restart_i,
  input wire logic selftest_i,
  output logic [11:0] program_counter_o,
  output logic [11:0] prog_addr_o,
  // Call, return and interrupt control
  input wire logic call_i,
  input wire logic return_i,
  input wire logic irq_take_i,
  input wire logic return_from_interrupt_i,
  output logic irq_mask_o,
  output logic int_mode_o,
  // Flag updates from the ALU
  input wire logic [1:0] carry_op_i,
  input wire logic alu_carry_i,
  input wire logic bit_value_i,
  input wire logic rotate_out_i,
  input wire logic zero_upd_i,
  input wire logic alu_zero_i,
  output logic carry_o,
  output logic zero_o,
  // Port and timer register values
  output logic [7:0] port_a_value_o,
  output logic [7:0] port_b_value_o,
  output logic [3:0] port_c_value_o,
  output logic [7:0] port_a_direction_o,
  output logic [7:0] port_b_direction_o,
  output logic [3:0] port_c_direction_o,
  output logic [7:0] timer_status_control_o
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] port_a_value_reg;  // Port A data
  logic [7:0] port_a_value_next;
  logic [7:0] port_b_value_reg;  // Port B data
  logic [7:0] port_b_value_next;
  logic [3:0] port_c_value_reg;  // Port C data, four bits
  logic [3:0] port_c_value_next;
  logic [7:0] port_a_dir_reg;  // Port A direction
  logic [7:0] port_a_dir_next;
  logic [7:0] port_b_dir_reg;  // Port B direction
  logic [7:0] port_b_dir_next;
  logic [3:0] port_c_dir_reg;  // Port C direction, four bits
  logic [3:0] port_c_dir_next;
  logic [7:0] timer_status_reg;  // Timer status and control
  logic [7:0] timer_status_next;
  logic [7:0] prescaler_reg;  // Prescaler value
  logic [7:0] prescaler_next;
  logic [7:0] timer_count_reg;  // Timer count value
  logic [7:0] timer_count_next;
  logic [7:0] acc_reg;  // Work accumulator
  logic [7:0] acc_next;
  logic [7:0] rdata_reg;  // Registered read data
  logic [7:0] rdata_next;
  logic ram_sel_reg;  // Last read hit RAM
  logic ram_sel_next;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit_ram;  // RAM window 80 to 9F, pointers included
  logic hit_drom;  // Data ROM window
  logic [7:0] ram_rdata;  // RAM read data
  logic [7:0] drom_rdata;  // Data ROM contents

  assign hit_ram = (data_addr_i >= cpu_state_pkg::ADDR_RAM_BASE) &&
                   (data_addr_i <= cpu_state_pkg::ADDR_RAM_LAST);
  assign hit_drom = (data_addr_i >= cpu_state_pkg::ADDR_DROM_BASE) &&
                    (data_addr_i <= cpu_state_pkg::ADDR_DROM_LAST);
  // Data ROM is mask content elsewhere; reads a fixed pattern here
  assign drom_rdata = cpu_state_pkg::UNMAPPED_FILL;

  // Pointers and scratch bytes sit in one RAM macro
  data_ram #(
    .AW(5),
    .DW(8)
  ) u_ram (
    .clk_i(clk_i),
    .we_i(data_wr_i && hit_ram),
    .waddr_i(data_addr_i[4:0]),
    .wdata_i(data_wdata_i),
    .raddr_i(data_addr_i[4:0]),
    .rdata_o(ram_rdata)
  );

  // Register writes and read mux; all through the data bus
  always_comb
  begin
    port_a_value_next = port_a_value_reg;
    port_b_value_next = port_b_value_reg;
    port_c_value_next = port_c_value_reg;
    port_a_dir_next = port_a_dir_reg;
    port_b_dir_next = port_b_dir_reg;
    port_c_dir_next = port_c_dir_reg;
    timer_status_next = timer_status_reg;
    prescaler_next = prescaler_reg;
    timer_count_next = timer_count_reg;
    acc_next = acc_reg;
    rdata_next = rdata_reg;
    ram_sel_next = 1'b0;
    if (data_wr_i)
    begin
      unique case (data_addr_i)
        cpu_state_pkg::ADDR_PORT_A_VALUE: port_a_value_next = data_wdata_i;
        cpu_state_pkg::ADDR_PORT_B_VALUE: port_b_value_next = data_wdata_i;
        cpu_state_pkg::ADDR_PORT_C_VALUE: port_c_value_next = data_wdata_i[3:0];
        cpu_state_pkg::ADDR_PORT_A_DIR: port_a_dir_next = data_wdata_i;
        cpu_state_pkg::ADDR_PORT_B_DIR: port_b_dir_next = data_wdata_i;
        cpu_state_pkg::ADDR_PORT_C_DIR: port_c_dir_next = data_wdata_i[3:0];
        cpu_state_pkg::ADDR_TIMER_STATUS: timer_status_next = data_wdata_i;
        cpu_state_pkg::ADDR_PRESCALER: prescaler_next = data_wdata_i;
        cpu_state_pkg::ADDR_TIMER_COUNT: timer_count_next = data_wdata_i;
        cpu_state_pkg::ADDR_ACCUMULATOR: acc_next = data_wdata_i;
        default: acc_next = acc_reg;  // Unmapped write ignored
      endcase
    end
    if (data_rd_i)
    begin
      unique case (data_addr_i)
        cpu_state_pkg::ADDR_PORT_A_VALUE: rdata_next = port_a_value_reg;
        cpu_state_pkg::ADDR_PORT_B_VALUE: rdata_next = port_b_value_reg;
        cpu_state_pkg::ADDR_PORT_C_VALUE:
          rdata_next = cpu_state_pkg::PORT_C_FIXED | {4'h0, port_c_value_reg};
        cpu_state_pkg::ADDR_PORT_A_DIR: rdata_next = port_a_dir_reg;
        cpu_state_pkg::ADDR_PORT_B_DIR: rdata_next = port_b_dir_reg;
        cpu_state_pkg::ADDR_PORT_C_DIR:
          rdata_next = cpu_state_pkg::PORT_C_FIXED | {4'h0, port_c_dir_reg};
        cpu_state_pkg::ADDR_TIMER_STATUS: rdata_next = timer_status_reg;
        cpu_state_pkg::ADDR_PRESCALER: rdata_next = prescaler_reg;
        cpu_state_pkg::ADDR_TIMER_COUNT: rdata_next = timer_count_reg;
        cpu_state_pkg::ADDR_ACCUMULATOR: rdata_next = acc_reg;
        default:
        begin
          // RAM data comes from the macro one cycle later
          ram_sel_next = hit_ram;
          rdata_next = hit_drom ? drom_rdata : cpu_state_pkg::UNMAPPED_FILL;
        end
      endcase
    end
  end

  // Register the data space state
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      port_a_value_reg <= cpu_state_pkg::PORT_RESET;
      port_b_value_reg <= cpu_state_pkg::PORT_RESET;
      port_c_value_reg <= 4'h0;
      port_a_dir_reg <= cpu_state_pkg::PORT_RESET;
      port_b_dir_reg <= cpu_state_pkg::PORT_RESET;
      port_c_dir_reg <= 4'h0;
      timer_status_reg <= cpu_state_pkg::TIMER_STATUS_RESET;
      prescaler_reg <= cpu_state_pkg::COUNT_RESET;
      timer_count_reg <= cpu_state_pkg::COUNT_RESET;
      acc_reg <= cpu_state_pkg::ACC_RESET;
      rdata_reg <= 8'h00;
      ram_sel_reg <= 1'b0;
    end
    else
    begin
      port_a_value_reg <= port_a_value_next;
      port_b_value_reg <= port_b_value_next;
      port_c_value_reg <= port_c_value_next;
      port_a_dir_reg <= port_a_dir_next;
      port_b_dir_reg <= port_b_dir_next;
      port_c_dir_reg <= port_c_dir_next;
      timer_status_reg <= timer_status_next;
      prescaler_reg <= prescaler_next;
      timer_count_reg <= timer_count_next;
      acc_reg <= acc_next;
      rdata_reg <= rdata_next;
      ram_sel_reg <= ram_sel_next;
    end
  end

  // ----------------------------------------------------------------
  // Program counter, mode and flags
  // ----------------------------------------------------------------
  logic [11:0] pc_reg;  // Counter, low byte plus high nibble
  logic [11:0] pc_next;
  logic mask_reg;  // Interrupt mask, set from reset
  logic mask_next;
  logic int_mode_reg;  // High selects interrupt flag copy
  logic int_mode_next;
  logic [1:0] carry_reg;  // Index 0 program, 1 interrupt
  logic [1:0] carry_next;
  logic [1:0] zero_reg;  // Index 0 program, 1 interrupt
  logic [1:0] zero_next;
  logic [11:0] stack_top;  // Top stack level
  logic cur_carry;  // Carry of the current mode
  logic [7:0] counter_low_byte;  // Low byte view
  logic [3:0] counter_high_nibble;  // High nibble view

  assign counter_low_byte = pc_reg[7:0];
  assign counter_high_nibble = pc_reg[11:8];
  assign cur_carry = carry_reg[int_mode_reg];

  // Return stack; pushes the counter, pops into it
  return_stack #(
    .WIDTH(cpu_state_pkg::PC_W),
    .DEPTH(cpu_state_pkg::STACK_DEPTH)
  ) u_stack (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .push_i(call_i || irq_take_i),
    .pop_i(return_i || return_from_interrupt_i),
    .push_data_i(pc_reg),
    .top_o(stack_top)
  );

  // Counter priority: restart, interrupt, return, load, increment
  always_comb
  begin
    pc_next = pc_reg;
    mask_next = mask_reg;
    int_mode_next = int_mode_reg;
    carry_next = carry_reg;
    zero_next = zero_reg;
    if (restart_i)
    begin
      pc_next = selftest_i ? cpu_state_pkg::VEC_ST_RESTART
                           : cpu_state_pkg::VEC_USER_RESTART;
    end
    else if (irq_take_i)
    begin
      pc_next = selftest_i ? cpu_state_pkg::VEC_ST_IRQ
                           : cpu_state_pkg::VEC_USER_IRQ;
      mask_next = 1'b1;
      int_mode_next = 1'b1;  // Copy kept as left last time
    end
    else if (return_i || return_from_interrupt_i)
    begin
      pc_next = stack_top;
      if (return_from_interrupt_i)
      begin
        mask_next = 1'b0;
        int_mode_next = 1'b0;
      end
    end
    else if (pc_load_i)
    begin
      pc_next = pc_load_value_i;
    end
    else if (pc_inc_i)
    begin
      pc_next = pc_reg + 12'h001;  // Wraps inside 4096 bytes
    end
    // Flag updates touch only the current copy
    unique case (cpu_state_pkg::carry_op_t'(carry_op_i))
      cpu_state_pkg::CARRY_KEEP: carry_next[int_mode_reg] = cur_carry;
      cpu_state_pkg::CARRY_ALU: carry_next[int_mode_reg] = alu_carry_i;
      cpu_state_pkg::CARRY_BIT: carry_next[int_mode_reg] = bit_value_i;
      cpu_state_pkg::CARRY_ROTATE: carry_next[int_mode_reg] = rotate_out_i;
    endcase
    if (zero_upd_i)
    begin
      zero_next[int_mode_reg] = alu_zero_i;
    end
  end

  // Register the control state; reset clears both flag copies
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pc_reg <= cpu_state_pkg::PC_RESET;
      mask_reg <= 1'b1;
      int_mode_reg <= 1'b0;
      carry_reg <= 2'b00;
      zero_reg <= 2'b00;
    end
    else
    begin
      pc_reg <= pc_next;
      mask_reg <= mask_next;
      int_mode_reg <= int_mode_next;
      carry_reg <= carry_next;
      zero_reg <= zero_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_rdata_o = ram_sel_reg ? ram_rdata : rdata_reg;
  assign program_counter_o = pc_reg;
  assign prog_addr_o = {counter_high_nibble, counter_low_byte};
  assign irq_mask_o = mask_reg;
  assign int_mode_o = int_mode_reg;
  assign carry_o = carry_reg[int_mode_reg];  // Current mode only
  assign zero_o = zero_reg[int_mode_reg];
  assign port_a_value_o = port_a_value_reg;
  assign port_b_value_o = port_b_value_reg;
  assign port_c_value_o = port_c_value_reg;
  assign port_a_direction_o = port_a_dir_reg;
  assign port_b_direction_o = port_b_dir_reg;
  assign port_c_direction_o = port_c_dir_reg;
  assign timer_status_control_o = timer_status_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  irq_vector_a: assert property (irq_take_i && !restart_i && !selftest_i |=>
    pc_reg == 12'hffc && mask_reg && int_mode_reg) else $error("interrupt entry wrong");
  rti_mode_a: assert property (return_from_interrupt_i && !restart_i && !irq_take_i |=>
    !int_mode_reg && !mask_reg) else $error("return did not restore mode");
  flag_other_a: assert property (int_mode_reg == $past(int_mode_reg) |->
    carry_reg[!int_mode_reg] == $past(carry_reg[!int_mode_reg])) else $error("other carry changed");
  int_keep_a: assert property (irq_take_i && !restart_i |=>
    carry_reg[1] == $past(carry_reg[1])) else $error("interrupt copy lost");
  carry_alu_a: assert property (carry_op_i == 2'd1 |=>
    carry_reg[$past(int_mode_reg)] == $past(alu_carry_i)) else $error("carry not updated");
  zero_upd_a: assert property (zero_upd_i |=>
    zero_reg[$past(int_mode_reg)] == $past(alu_zero_i)) else $error("zero not updated");
  call_ret_a: assert property (call_i && !irq_take_i && !restart_i ##1
    return_i && !call_i && !irq_take_i && !restart_i && !return_from_interrupt_i |=>
    pc_reg == $past(pc_reg, 2)) else $error("return address wrong");
  portc_read_a: assert property (data_rd_i && data_addr_i == 8'h02 |=>
    data_rdata_o[7:4] == 4'hf) else $error("port C upper bits not ones");
  unmapped_a: assert property (data_rd_i && data_addr_i == 8'h03 |=>
    data_rdata_o == 8'hff) else $error("unmapped read wrong");
  acc_write_a: assert property (data_wr_i && data_addr_i == 8'hff |=>
    acc_reg == $past(data_wdata_i)) else $error("accumulator write lost");

  irq_cover_c: cover property (irq_take_i ##[1:20] return_from_interrupt_i);
  deep_pop_c: cover property (return_i ##1 return_i ##1 return_i ##1 return_i ##1 return_i);
  ram_read_c: cover property (data_rd_i && hit_ram);

endmodule

`default_nettype wire

// File: testbench/core_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

// Core side of the data bus: one strobe per access, released at next fall
module core_bus_model (
  // Clock and read data
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  // Bus request
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Write one byte; data line shows inverse once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
    // Idle cycle, so a following call never drives the strobe twice in one step
    @(negedge clk_i);
  endtask
  // Read one byte; answer is registered, taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    d = rdata_i;
    // Idle cycle between reads for the same reason
    @(negedge clk_i);
  endtask
endmodule

`default_nettype wire

// File: testbench/cpu_state_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_state_regs_tb;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] a, rd, wd, q;
  logic r, w, sel = 1'b0;
  logic [6:0] ctl = 7'h00; // load,inc,restart,call,ret,irq,rti
  logic [11:0] lv = 12'h000;
  logic [1:0] cop = 2'h0;
  logic cv = 1'b0, zu = 1'b0, zv = 1'b0;
  logic [11:0] pc, pa;
  logic msk, im, c, z;
  logic [7:0] pav, pbv, pad, pbd, tsc;
  logic [3:0] pcv, pcd;
  int n_fail = 0, n_checks = 0;
  logic [7:0] ta[15] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h03,
    8'h07, 8'h10, 8'h20, 8'h80, 8'h81, 8'hff, 8'ha0};
  logic [7:0] te[15] = '{8'ha5, 8'h5a, 8'hfc, 8'hc3, 8'h96, 8'hff, 8'h35, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h11, 8'h22, 8'h77, 8'hff};
  logic [7:0] td[15] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h96, 8'h0f, 8'h35, 8'h12,
    8'h34, 8'h55, 8'h66, 8'h11, 8'h22, 8'h77, 8'h99};
  // 250 MHz core clock
  always #2 clk = ~clk;
  core_bus_model i_core (.clk_i(clk), .rdata_i(rd), .addr_o(a), .rd_o(r), .wr_o(w),
    .wdata_o(wd));
  cpu_state_regs i_dut (.clk_i(clk), .rstn_i(rstn), .data_addr_i(a), .data_rd_i(r),
    .data_wr_i(w), .data_wdata_i(wd), .data_rdata_o(rd), .pc_load_i(ctl[6]),
    .pc_load_value_i(lv), .pc_inc_i(ctl[5]), .restart_i(ctl[4]), .selftest_i(sel),
    .program_counter_o(pc), .prog_addr_o(pa), .call_i(ctl[3]), .return_i(ctl[2]),
    .irq_take_i(ctl[1]), .return_from_interrupt_i(ctl[0]), .irq_mask_o(msk),
    .int_mode_o(im), .carry_op_i(cop), .alu_carry_i(cv), .bit_value_i(cv),
    .rotate_out_i(cv), .zero_upd_i(zu), .alu_zero_i(zv), .carry_o(c), .zero_o(z),
    .port_a_value_o(pav), .port_b_value_o(pbv), .port_c_value_o(pcv),
    .port_a_direction_o(pad), .port_b_direction_o(pbd), .port_c_direction_o(pcd),
    .timer_status_control_o(tsc));
  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  // Compare with case equality so unknowns never match
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // One-cycle control pulse
  task automatic op(input logic [6:0] v);
    ctl = v;
    @(negedge clk);
    ctl = 7'h00;
    // Idle cycle; state holds, next call starts on a fresh edge
    @(negedge clk);
  endtask
  // One-cycle flag update
  task automatic flg(input logic [1:0] o, input logic v, input logic u, input logic zz);
    cop = o;
    cv = v;
    zu = u;
    zv = zz;
    @(negedge clk);
    cop = 2'h0;
    zu = 1'b0;
    @(negedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    chk("carry", c, 0);
    chk("zero", z, 0);
    chk("mask", msk, 1);
    chk("mode", im, 0);
    $display("test reset done");
    // All writes first, so an unmapped write cannot hide behind a read
    for (int i = 0; i < 15; i++) i_core.wr(ta[i], td[i]);
    for (int i = 0; i < 15; i++)
    begin
      i_core.rd(ta[i], q);
      chk("rdata", q, te[i]);
    end
    chk("port_c_out", pcv, 4'hc);
    chk("port_a_out", pav, 8'ha5);
    chk("port_b_out", pbv, 8'h5a);
    chk("dir_a_out", pad, 8'hc3);
    chk("dir_b_out", pbd, 8'h96);
    chk("dir_c_out", pcd, 4'hf);
    chk("timer_out", tsc, 8'h35);
    $display("test registers done");
    // Vectors, plain and self-test
    op(7'h10);
    chk("restart", pc, 12'hffe);
    op(7'h20);
    chk("inc", pa, 12'hfff);
    sel = 1'b1;
    op(7'h10);
    chk("st_restart", pc, 12'hffa);
    sel = 1'b0;
    $display("test vectors done");
    // Four pushes then five pops; last pop repeats the bottom level
    for (int i = 0; i < 4; i++)
    begin
      lv = 12'hc00 + 12'(i * 17);
      op(7'h40);
      op(7'h08);
    end
    // Back-to-back pops, then a call with increment right before a return
    for (int i = 3; i >= -1; i--)
    begin
      ctl = 7'h04;
      @(negedge clk);
      chk("pop", pc, 12'hc00 + 12'((i < 0 ? 0 : i) * 17));
    end
    ctl = 7'h28;
    @(negedge clk);
    ctl = 7'h04;
    @(negedge clk);
    ctl = 7'h00;
    chk("call_ret", pc, 12'hc00);
    $display("test stack done");
    // Flags per mode
    flg(2'h1, 1'b1, 1'b1, 1'b1);
    chk("carry_alu", c, 1);
    chk("zero_set", z, 1);
    flg(2'h1, 1'b0, 1'b1, 1'b0);
    chk("carry_clr", c, 0);
    chk("zero_clr", z, 0);
    flg(2'h2, 1'b1, 1'b1, 1'b1);
    chk("carry_bit", c, 1);
    lv = 12'hc40;
    op(7'h40);
    op(7'h02);
    chk("irq_pc", pc, 12'hffc);
    chk("irq_mode", im, 1);
    chk("irq_mask", msk, 1);
    chk("irq_carry", c, 0);
    flg(2'h3, 1'b1, 1'b0, 1'b0);
    chk("carry_rot", c, 1);
    op(7'h01);
    chk("rti_pc", pc, 12'hc40);
    chk("rti_mask", msk, 0);
    chk("prog_zero", z, 1);
    sel = 1'b1;
    op(7'h02);
    chk("st_irq_pc", pc, 12'hff8);
    chk("kept_carry", c, 1);
    $display("test flags done");
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    chk("reset_carry", c, 0);
    chk("reset_zero", z, 0);
    chk("reset_mode", im, 0);
    $display("test second reset done");
    summarize();
  end
endmodule

`default_nettype wire
